// ===== common/ebw_regs.svh
// register indices, field positions and reset values of the bus wait block
// assumes a 3-bit register index and 16-bit register data
`ifndef EBW_REGS_SVH
`define EBW_REGS_SVH
`define EBW_A_DWC      3'h0
`define EBW_A_ADW      3'h1
`define EBW_A_IDL      3'h2
`define EBW_A_CTRL     3'h3
`define EBW_A_STAT     3'h4
`define EBW_DWC_RST    16'h7777
`define EBW_ADW_RST    16'hFFFF
`define EBW_IDL_RST    16'hAAAA
`define EBW_CTRL_RST   1'b0
`define EBW_DWC_STRIDE 4
`define EBW_DWC_W      3
`define EBW_ADW_STRIDE 2
`define EBW_ADW_SETUP  0
`define EBW_ADW_HOLD   1
`define EBW_IDL_STRIDE 2
`define EBW_IDL_EN     1
`define EBW_CTRL_SEP   0
`define EBW_CTRL_HPIN  1
`define EBW_AREA_MSB   23
`define EBW_AREA_LSB   21
`endif

// ===== common/ebw_pkg.sv
// types of the external bus wait, idle and hold block
// constants live in ebw_regs.svh
package ebw_pkg;
    typedef enum logic [3:0] {
        ST_FREE, ST_ASETUP, ST_ADDR, ST_AHOLD, ST_DATA, ST_WAIT,
        ST_END, ST_IDLE_INS, ST_PERI, ST_FLOAT, ST_HOLD, ST_RESUME
    } ebw_bst_t;
    typedef enum logic [1:0] {SP_EXT, SP_MEM, SP_PERI} ebw_space_t;
    typedef enum logic [1:0] {K_OP, K_BR, K_SQ} ebw_kind_t;
    typedef struct packed {
        ebw_bst_t    st;
        logic        ph;
        logic [2:0]  wsync;
        logic [2:0]  hsync;
        logic        wpin;
        logic        hpin;
        logic        wsmp;
        logic [2:0]  wcnt;
        logic [1:0]  area;
        logic [23:0] addr;
        logic        wr;
        logic        lk;
        logic        lock;
        ebw_kind_t   kind;
        logic [15:0] dwc;
        logic [15:0] adw;
        logic [15:0] idl;
        logic        sep;
        logic        hpin_en;
        logic [15:0] rdata;
        logic [3:0]  cs_n;
        logic        rd_n;
        logic        wr_n;
        logic        oe;
        logic        grant_n;
        logic        op_ack;
        logic        br_ack;
        logic        sq_ack;
    } ebw_state_t;
endpackage

// ===== rtl/ebw_ctrl.sv
// external bus cycle sequencer: data waits, wait pin, address waits,
// idle insertion after reads and bus hold grant
// assumes a cpu request port held until acknowledged, a plain register port
// and pins on the far side of the chip pads
//
// Functional notes
// - per area zero to seven data waits
// - reset gives seven data waits everywhere
// - internal memory no waits, peripherals own waits
// - wait pin asynchronous, synchronised, unlimited stretch
// - multiplexed mode samples wait on falling edge
// - separate mode samples wait on rising edge
// - internal accesses ignore the wait pin
// - programmed and pin waits are ORed
// - setup wait adds one clock before address
// - hold wait adds one clock after address
// - address wait register per area, resets ones
// - internal accesses get no address waits
// - idle state only after external reads
// - idle control register resets enabling all areas
// - internal accesses get no idle state
// - hold pins work only in control mode
// - on request float bus, then grant
// - request release ends grant, bus driven again
// - internal memory keeps running during hold
// - no hold between split sized accesses
// - no hold inside read-modify-write pair
// - no hold in stop or idle modes
// - halt mode grants and releases hold directly
// - priority hold, operand, branch, sequential fetch
// - fixed areas of 2, 2, 4, 8 MB
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "ebw_regs.svh"
module ebw_ctrl
    import ebw_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic [15:0]      reg_rdata,
    // operand requests
    input  wire logic        op_req,
    input  wire logic [23:0] op_addr,
    input  wire logic [1:0]  op_space,
    input  wire logic        op_write,
    input  wire logic        op_lock,
    output logic             op_ack,
    // instruction fetch requests
    input  wire logic        br_req,
    input  wire logic        sq_req,
    input  wire logic [23:0] fetch_addr,
    input  wire logic [1:0]  fetch_space,
    output logic             br_ack,
    output logic             sq_ack,
    // power mode and peripheral
    input  wire logic        pwr_stop,
    input  wire logic        periph_busy,
    // external bus pins
    input  wire logic        ext_wait_n,
    input  wire logic        hold_request_n,
    output logic             sys_clock_out,
    output logic [3:0]       area_select_n,
    output logic [23:0]      bus_addr,
    output logic             bus_oe,
    output logic             rd_strobe_n,
    output logic             wr_strobe_n,
    output logic             hold_grant_n
);

    localparam ebw_state_t RST_S = '{
        st:      ST_FREE,
        kind:    K_OP,
        wsync:   3'h7,
        hsync:   3'h7,
        wpin:    1'b1,
        hpin:    1'b1,
        dwc:     `EBW_DWC_RST,
        adw:     `EBW_ADW_RST,
        idl:     `EBW_IDL_RST,
        sep:     `EBW_CTRL_RST,
        hpin_en: `EBW_CTRL_RST,
        cs_n:    4'hF,
        rd_n:    1'b1,
        wr_n:    1'b1,
        oe:      1'b1,
        grant_n: 1'b1,
        default: '0
    };

    ebw_state_t  s_q;
    ebw_state_t  s_d;
    logic        step;
    logic        k_req;
    logic        k_wr;
    logic [23:0] k_addr;
    logic [1:0]  k_space;
    logic [1:0]  k_area;
    ebw_kind_t   k_kind;
    logic        hold_want;
    logic        hold_ok;
    logic        wneed;
    logic        leave_addr;
    logic        go_wait;
    logic        fin;
    logic        done;
    logic        ack_now;
    ebw_kind_t   ack_kind;

    // fixed area map inside the lower 16 MB
    function automatic logic [1:0] area_of(input logic [23:0] a);
        logic [2:0] top;
        top = a[`EBW_AREA_MSB:`EBW_AREA_LSB];
        unique case (top)
            3'h0:       area_of = 2'h0;
            3'h1:       area_of = 2'h1;
            3'h2, 3'h3: area_of = 2'h2;
            default:    area_of = 2'h3;
        endcase
    endfunction

    // request priority: operand, branch fetch, sequential fetch
    always_comb begin
        k_req   = 1'b1;
        k_kind  = K_OP;
        k_addr  = op_addr;
        k_space = op_space;
        k_wr    = op_write;
        if (op_req) begin
            k_kind = K_OP;
        end else if (br_req) begin
            k_kind  = K_BR;
            k_addr  = fetch_addr;
            k_space = fetch_space;
            k_wr    = 1'b0;
        end else if (sq_req) begin
            k_kind  = K_SQ;
            k_addr  = fetch_addr;
            k_space = fetch_space;
            k_wr    = 1'b0;
        end else begin
            k_req = 1'b0;
        end
        k_area = area_of(k_addr);
    end

    always_comb begin
        s_d        = s_q;
        s_d.op_ack = 1'b0;
        s_d.br_ack = 1'b0;
        s_d.sq_ack = 1'b0;
        // bus clock runs at half rate; step marks its rising edge
        s_d.ph = ~s_q.ph;
        step   = ~s_q.ph;
        // pins pass three flops; a change counts when stages two and three agree
        s_d.wsync = {s_q.wsync[1:0], ext_wait_n};
        s_d.hsync = {s_q.hsync[1:0], hold_request_n};
        if (s_q.wsync[1] == s_q.wsync[2]) begin
            s_d.wpin = s_q.wsync[2];
        end
        if (s_q.hsync[1] == s_q.hsync[2]) begin
            s_d.hpin = s_q.hsync[2];
        end
        if (reg_we) begin
            case (reg_addr)
                `EBW_A_DWC: s_d.dwc = reg_wdata;
                `EBW_A_ADW: s_d.adw = reg_wdata;
                `EBW_A_IDL: s_d.idl = reg_wdata;
                `EBW_A_CTRL: begin
                    s_d.sep     = reg_wdata[`EBW_CTRL_SEP];
                    s_d.hpin_en = reg_wdata[`EBW_CTRL_HPIN];
                end
                default: ;
            endcase
        end
        if (reg_re) begin
            s_d.rdata = 16'h0000;
            case (reg_addr)
                `EBW_A_DWC: s_d.rdata = s_q.dwc;
                `EBW_A_ADW: s_d.rdata = s_q.adw;
                `EBW_A_IDL: s_d.rdata = s_q.idl;
                `EBW_A_CTRL: begin
                    s_d.rdata[`EBW_CTRL_SEP]  = s_q.sep;
                    s_d.rdata[`EBW_CTRL_HPIN] = s_q.hpin_en;
                end
                `EBW_A_STAT: s_d.rdata = {8'h00, s_q.oe, s_q.lock, ~s_q.grant_n,
                                          ~s_q.wpin, 4'(s_q.st)};
                default: ;
            endcase
        end
        hold_want = s_q.hpin_en & ~s_q.hpin;
        // halt needs no special case: a quiet bus grants at once
        hold_ok = hold_want & ~pwr_stop & ~s_q.lock;
        // separate mode looks at the pin at this rising edge,
        // multiplexed mode at the falling edge before it
        wneed = (s_q.wcnt != 3'h0) | (s_q.sep ? ~s_q.wpin : s_q.wsmp);
        if (s_q.ph && !s_q.sep && (s_q.st == ST_DATA || s_q.st == ST_WAIT)) begin
            s_d.wsmp = ~s_q.wpin;
        end
        leave_addr = 1'b0;
        go_wait    = 1'b0;
        fin        = 1'b0;
        done       = 1'b0;
        ack_now    = 1'b0;
        ack_kind   = s_q.kind;
        unique case (s_q.st)
            ST_FREE: begin
                if (step && hold_ok) begin
                    s_d.st = ST_FLOAT;
                    s_d.oe = 1'b0;
                end else if (step && k_req) begin
                    s_d.kind = k_kind;
                    s_d.lk   = (k_kind == K_OP) & op_lock;
                    if (k_space == SP_MEM) begin
                        ack_now  = 1'b1;
                        ack_kind = k_kind;
                    end else if (k_space == SP_PERI) begin
                        s_d.st = ST_PERI;
                    end else begin
                        s_d.addr = k_addr;
                        s_d.wr   = k_wr;
                        s_d.area = k_area;
                        s_d.wsmp = 1'b0;
                        s_d.wcnt = s_q.dwc[`EBW_DWC_STRIDE*k_area +: `EBW_DWC_W];
                        s_d.cs_n = ~(4'h1 << k_area);
                        if (s_q.adw[`EBW_ADW_STRIDE*k_area + `EBW_ADW_SETUP]) begin
                            s_d.st = ST_ASETUP;
                        end else begin
                            s_d.st = ST_ADDR;
                        end
                    end
                end
            end
            ST_ASETUP: begin
                if (step) begin
                    s_d.st = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (step && s_q.adw[`EBW_ADW_STRIDE*s_q.area + `EBW_ADW_HOLD]) begin
                    s_d.st = ST_AHOLD;
                end else begin
                    leave_addr = step;
                end
            end
            ST_AHOLD: begin
                leave_addr = step;
            end
            ST_DATA: begin
                if (step) begin
                    if (!s_q.sep && wneed) begin
                        go_wait = 1'b1;
                    end else if (!s_q.sep) begin
                        s_d.st = ST_END;
                    end else begin
                        fin = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                // select, strobes and address are left untouched here
                if (step && wneed) begin
                    go_wait = 1'b1;
                end else if (step) begin
                    s_d.st = s_q.sep ? ST_DATA : ST_END;
                end
            end
            ST_END: begin
                fin = step;
            end
            ST_IDLE_INS: begin
                done = step;
            end
            ST_PERI: begin
                done = step & ~periph_busy;
            end
            ST_FLOAT: begin
                if (step) begin
                    s_d.st      = ST_HOLD;
                    s_d.grant_n = 1'b0;
                end
            end
            ST_HOLD: begin
                if (step && k_req && k_space == SP_MEM) begin
                    ack_now  = 1'b1;
                    ack_kind = k_kind;
                end
                if (step && !hold_want) begin
                    s_d.st      = ST_RESUME;
                    s_d.grant_n = 1'b1;
                end
            end
            ST_RESUME: begin
                if (step) begin
                    s_d.st = ST_FREE;
                    s_d.oe = 1'b1;
                end
            end
            default: s_d.st = ST_FREE;
        endcase
        if (leave_addr) begin
            s_d.rd_n = s_q.wr;
            s_d.wr_n = ~s_q.wr;
            if (s_q.sep && wneed) begin
                go_wait = 1'b1;
            end else begin
                s_d.st = ST_DATA;
            end
        end
        if (go_wait) begin
            s_d.st = ST_WAIT;
            if (s_q.wcnt != 3'h0) begin
                s_d.wcnt = s_q.wcnt - 3'h1;
            end
        end
        if (fin) begin
            if (!s_q.wr && s_q.idl[`EBW_IDL_STRIDE*s_q.area + `EBW_IDL_EN]) begin
                s_d.st   = ST_IDLE_INS;
                s_d.cs_n = 4'hF;
                s_d.rd_n = 1'b1;
            end else begin
                done = 1'b1;
            end
        end
        if (done) begin
            s_d.st   = ST_FREE;
            s_d.cs_n = 4'hF;
            s_d.rd_n = 1'b1;
            s_d.wr_n = 1'b1;
            ack_now  = 1'b1;
            if (s_q.kind == K_OP) begin
                s_d.lock = s_q.lk;
            end
        end
        if (ack_now) begin
            unique case (ack_kind)
                K_OP:    s_d.op_ack = 1'b1;
                K_BR:    s_d.br_ack = 1'b1;
                default: s_d.sq_ack = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= RST_S;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata     = s_q.rdata;
    assign op_ack        = s_q.op_ack;
    assign br_ack        = s_q.br_ack;
    assign sq_ack        = s_q.sq_ack;
    assign sys_clock_out = s_q.ph;
    assign area_select_n = s_q.cs_n;
    assign bus_addr      = s_q.addr;
    assign bus_oe        = s_q.oe;
    assign rd_strobe_n   = s_q.rd_n;
    assign wr_strobe_n   = s_q.wr_n;
    assign hold_grant_n  = s_q.grant_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_float_grant;
        (!s_q.oe && s_q.grant_n) [*2] ##1 (!s_q.oe && !s_q.grant_n);
    endsequence

    sequence s_resume;
        !s_q.oe ##1 !s_q.oe ##1 s_q.oe;
    endsequence

    a_mem_no_bus: assert property (
        (s_q.st == ST_FREE && step && !hold_ok && k_req && k_space == SP_MEM)
        |=> (s_q.cs_n == 4'hF && (s_q.op_ack || s_q.br_ack || s_q.sq_ack)))
        else $error("internal access touched the bus");

    a_wait_cause: assert property (
        (step && s_d.st == ST_WAIT)
        |-> (s_q.wcnt != 3'h0 || (s_q.sep ? !s_q.wpin : s_q.wsmp)))
        else $error("wait state without a cause");

    a_wait_exit: assert property (
        (step && s_q.st == ST_WAIT && s_d.st != ST_WAIT)
        |-> (s_q.wcnt == 3'h0 && !(s_q.sep ? !s_q.wpin : s_q.wsmp)))
        else $error("wait left while still needed");

    a_wait_stable: assert property (
        s_q.st == ST_WAIT |=> ($stable(s_q.addr) && $stable(s_q.cs_n) && $stable(s_q.rd_n)))
        else $error("bus moved during a wait");

    a_setup_wait: assert property (
        s_q.st == ST_ASETUP |-> ##[1:2] s_q.st == ST_ADDR)
        else $error("setup wait not one bus clock");

    a_idle_read: assert property (
        s_q.st == ST_IDLE_INS |-> (!s_q.wr && s_q.rd_n && s_q.cs_n == 4'hF))
        else $error("idle state on a write or with strobe");

    a_hold_entry: assert property (
        (s_q.st == ST_FREE && s_d.st == ST_FLOAT) |=> s_float_grant)
        else $error("grant not preceded by a floated bus");

    a_hold_ok: assert property (
        (s_q.st != ST_FLOAT && s_d.st == ST_FLOAT)
        |-> (s_q.hpin_en && !s_q.lock && !pwr_stop))
        else $error("hold taken when not allowed");

    a_hold_exit: assert property (
        $rose(s_q.grant_n) |-> s_resume)
        else $error("bus not driven again after release");

    a_mem_in_hold: assert property (
        (s_q.st == ST_HOLD && step && k_req && k_space == SP_MEM)
        |=> ((s_q.op_ack || s_q.br_ack || s_q.sq_ack) && !s_q.grant_n))
        else $error("internal access stalled by hold");

endmodule

// ===== verification/ebw_far_side.sv
// far side of the external bus: a slow device on the wait pin and a second bus master
// assumes link_clk is unrelated in phase to the block clock
`timescale 1ns/1ps
module ebw_far_side (
    // link clock and bench commands
    input  wire logic       link_clk,
    input  wire logic [3:0] wait_len,
    input  wire logic       wait_hold,
    input  wire logic       hold_cmd,
    // block pins
    input  wire logic [3:0] area_select_n,
    output logic            ext_wait_n,
    output logic            hold_request_n
);
    logic       go_q   = 1'b0;
    logic       seen_q = 1'b0;
    logic [3:0] cnt_q  = 4'h0;
    wire        sel    = (area_select_n != 4'hF);

    // mark the start of every selected cycle
    always @(posedge sel) begin
        go_q <= ~go_q;
    end

    // stretch each cycle by wait_len link clocks, async to the block
    always @(posedge link_clk) begin
        seen_q <= go_q;
        if (go_q != seen_q) begin
            cnt_q <= wait_len;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    // a slow device holds the pin low while not ready and lets go
    // wait_len link clocks after it is selected, so the filter sees it in time
    assign ext_wait_n     = !wait_hold && (wait_len == 4'h0 || (sel && go_q == seen_q && cnt_q == 4'h0));
    // the other master releases by driving the request high
    assign hold_request_n = !hold_cmd;
endmodule

// ===== verification/ebw_ctrl_test.sv
// self-checking bench of the bus wait, idle and hold sequencer
// assumes the far-side model and the register indices of the common header
`timescale 1ns/1ps
`include "ebw_regs.svh"
module ebw_ctrl_test;
    logic        clk;
    logic        arst_n;
    logic        link_clk;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_we;
    logic        reg_re;
    logic [15:0] reg_rdata;
    logic        op_req;
    logic [23:0] op_addr;
    logic [1:0]  op_space;
    logic        op_write;
    logic        op_lock;
    logic        op_ack;
    logic        br_req;
    logic        sq_req;
    logic [23:0] fetch_addr;
    logic [1:0]  fetch_space;
    logic        br_ack;
    logic        sq_ack;
    logic        pwr_stop;
    logic        periph_busy;
    logic        ext_wait_n;
    logic        hold_request_n;
    logic        sys_clock_out;
    logic [3:0]  area_select_n;
    logic [23:0] bus_addr;
    logic        bus_oe;
    logic        rd_strobe_n;
    logic        wr_strobe_n;
    logic        hold_grant_n;
    logic [3:0]  wait_len;
    logic        wait_hold;
    logic        hold_cmd;
    int          fails;
    int          n_compared;
    int          ni;
    int          b0;
    int          bw;
    int          s0;
    int          n;
    int          k;
    logic [3:0]  cs_seen;
    logic [23:0] ad_seen;
    logic        wr_seen;

    // clocks from request to acknowledge: internal, multiplexed, separate
    localparam int lat_int = 1;
    localparam int lat_mux = 7;
    localparam int lat_sep = 5;

    ebw_ctrl u_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .op_req(op_req), .op_addr(op_addr), .op_space(op_space),
        .op_write(op_write), .op_lock(op_lock), .op_ack(op_ack), .br_req(br_req), .sq_req(sq_req),
        .fetch_addr(fetch_addr), .fetch_space(fetch_space), .br_ack(br_ack), .sq_ack(sq_ack),
        .pwr_stop(pwr_stop), .periph_busy(periph_busy), .ext_wait_n(ext_wait_n),
        .hold_request_n(hold_request_n), .sys_clock_out(sys_clock_out), .area_select_n(area_select_n),
        .bus_addr(bus_addr), .bus_oe(bus_oe), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
        .hold_grant_n(hold_grant_n));

    ebw_far_side u_far (.link_clk(link_clk), .wait_len(wait_len), .wait_hold(wait_hold), .hold_cmd(hold_cmd),
        .area_select_n(area_select_n), .ext_wait_n(ext_wait_n), .hold_request_n(hold_request_n));

    always #10 clk = ~clk;

    // select, address and direction seen while a strobe is low
    always @(posedge clk) begin
        if (!rd_strobe_n || !wr_strobe_n) begin
            cs_seen <= area_select_n;
            ad_seen <= bus_addr;
            wr_seen <= !wr_strobe_n;
        end
    end

    initial begin
        link_clk = 1'b0;
        #3;
        forever #80 link_clk = ~link_clk;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic final_report;
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re   <= 1'b0;
        #1;
        check("reg_rdata", {16'h0, reg_rdata}, {16'h0, e});
    endtask

    // wait until the next edge is not a decision edge, so latencies line up
    task automatic align;
        @(posedge clk);
        #1;
        while (sys_clock_out !== 1'b1) begin
            @(posedge clk);
            #1;
        end
    endtask

    // one operand access, returns clocks from request to acknowledge
    task automatic acc(input logic [23:0] a, input logic [1:0] sp, input logic w, output int c);
        align();
        @(posedge clk);
        op_addr  <= a;
        op_space <= sp;
        op_write <= w;
        op_req   <= 1'b1;
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (op_ack !== 1'b1 && c < 400);
        check("op_ack", {31'h0, op_ack}, 32'h1);
        @(posedge clk);
        op_req <= 1'b0;
    endtask

    initial begin
        #400000;
        fails++;
        final_report();
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        reg_we = 1'b0;
        reg_re = 1'b0;
        op_req = 1'b0;
        op_addr = 24'h000000;
        op_space = 2'h0;
        op_write = 1'b0;
        op_lock = 1'b0;
        br_req = 1'b0;
        sq_req = 1'b0;
        fetch_addr = 24'h000000;
        fetch_space = 2'h1;
        pwr_stop = 1'b0;
        periph_busy = 1'b0;
        wait_len = 4'h0;
        wait_hold = 1'b0;
        hold_cmd = 1'b0;
        fails = 0;
        n_compared = 0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rd(`EBW_A_DWC, 16'h7777);
        rd(`EBW_A_ADW, 16'hFFFF);
        rd(`EBW_A_IDL, 16'hAAAA);
        rd(3'h7, 16'h0000);
        acc(24'h000000, 2'h1, 1'b0, ni);
        check("int_rst", 32'(ni), 32'(lat_int));
        wr(`EBW_A_DWC, 16'h0000);
        wr(`EBW_A_ADW, 16'h0000);
        wr(`EBW_A_IDL, 16'h0000);
        rd(`EBW_A_ADW, 16'h0000);
        acc(24'h000000, 2'h1, 1'b0, n);
        check("int_lat", 32'(n), 32'(lat_int));
        acc(24'h000000, 2'h0, 1'b0, b0);
        check("mux_rd", 32'(b0), 32'(lat_mux));
        acc(24'h000000, 2'h0, 1'b1, bw);
        check("mux_wr", 32'(bw), 32'(lat_mux));
        check("wr_seen", {31'h0, wr_seen}, 32'h1);
        check("cs_area0", {28'h0, cs_seen}, 32'hE);
        // data waits: each adds one bus clock of two system clocks
        wr(`EBW_A_DWC, 16'h0003);
        acc(24'h000000, 2'h0, 1'b0, n);
        check("dw_area0", 32'(n), 32'(lat_mux + 6));
        wr(`EBW_A_DWC, 16'h7000);
        acc(24'h800000, 2'h0, 1'b0, n);
        check("dw_area3", 32'(n), 32'(lat_mux + 14));
        check("cs_area3", {28'h0, cs_seen}, 32'h7);
        check("addr_area3", {8'h0, ad_seen}, 32'h800000);
        acc(24'h400000, 2'h0, 1'b0, n);
        check("dw_area2", 32'(n), 32'(lat_mux));
        check("cs_area2", {28'h0, cs_seen}, 32'hB);
        wr(`EBW_A_DWC, 16'h0000);
        wr(`EBW_A_ADW, 16'h0003);
        acc(24'h000000, 2'h0, 1'b0, n);
        check("aw_both", 32'(n), 32'(lat_mux + 4));
        wr(`EBW_A_ADW, 16'h0001);
        acc(24'h000000, 2'h0, 1'b0, n);
        check("aw_setup", 32'(n), 32'(lat_mux + 2));
        wr(`EBW_A_ADW, 16'h0000);
        wr(`EBW_A_IDL, 16'h0002);
        acc(24'h000000, 2'h0, 1'b0, n);
        check("idle_rd", 32'(n), 32'(lat_mux + 2));
        acc(24'h000000, 2'h0, 1'b1, n);
        check("idle_wr", 32'(n), 32'(lat_mux));
        wr(`EBW_A_IDL, 16'h0000);
        // wait pin stretches beyond the programmed count
        wait_len <= 4'hC;
        acc(24'h000000, 2'h0, 1'b0, n);
        check("wpin_mux", 32'(n > lat_mux + 40), 32'h1);
        wait_len <= 4'h0;
        wait_hold <= 1'b1;
        acc(24'h000000, 2'h1, 1'b0, n);
        check("wpin_int", 32'(n), 32'(lat_int));
        wait_hold <= 1'b0;
        // separate bus mode
        wr(`EBW_A_CTRL, 16'h0001);
        acc(24'h000000, 2'h0, 1'b0, s0);
        check("sep_rd", 32'(s0), 32'(lat_sep));
        wr(`EBW_A_DWC, 16'h0002);
        acc(24'h000000, 2'h0, 1'b0, n);
        check("dw_sep", 32'(n), 32'(lat_sep + 4));
        wr(`EBW_A_DWC, 16'h0000);
        wait_len <= 4'hC;
        acc(24'h000000, 2'h0, 1'b0, n);
        check("wpin_sep", 32'(n > lat_sep + 40), 32'h1);
        wait_len <= 4'h0;
        // hold pins off, then a locked access, then stop mode: no grant
        hold_cmd <= 1'b1;
        wr(`EBW_A_CTRL, 16'h0000);
        op_lock <= 1'b1;
        acc(24'h000000, 2'h0, 1'b0, n);
        op_lock <= 1'b0;
        repeat (40) @(posedge clk);
        check("hold_off", {31'h0, hold_grant_n}, 32'h1);
        pwr_stop <= 1'b1;
        wr(`EBW_A_CTRL, 16'h0002);
        repeat (40) @(posedge clk);
        check("hold_stop", {31'h0, hold_grant_n}, 32'h1);
        pwr_stop <= 1'b0;
        repeat (40) @(posedge clk);
        check("hold_lock", {31'h0, hold_grant_n}, 32'h1);
        acc(24'h000000, 2'h0, 1'b0, n);
        check("lock_end", 32'(n), 32'(lat_mux));
        for (k = 0; k < 100 && hold_grant_n !== 1'b0; k++) begin
            @(posedge clk);
            #1;
        end
        check("hold_grant", {31'h0, hold_grant_n}, 32'h0);
        check("hold_float", {31'h0, bus_oe}, 32'h0);
        acc(24'h000000, 2'h1, 1'b0, n);
        check("hold_int", 32'(n), 32'(lat_int));
        hold_cmd <= 1'b0;
        for (k = 0; k < 100 && hold_grant_n !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check("hold_rel", {31'h0, hold_grant_n}, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        check("hold_drive", {31'h0, bus_oe}, 32'h1);
        // operand access beats a branch fetch
        align();
        @(posedge clk);
        op_space <= 2'h1;
        op_req <= 1'b1;
        br_req <= 1'b1;
        for (k = 0; k < 100 && op_ack !== 1'b1 && br_ack !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check("prio", {30'h0, op_ack, br_ack}, 32'h2);
        @(posedge clk);
        op_req <= 1'b0;
        for (k = 0; k < 100 && br_ack !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check("br_done", {31'h0, br_ack}, 32'h1);
        @(posedge clk);
        br_req <= 1'b0;
        final_report();
    end
endmodule
